// ### bench/srb_checker_assertions.sv
// Port-level checker for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module srb_checker
    import srb_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic busClkEn,
    input wire logic waitReq,
    input wire logic cpuClkEn,
    input wire logic periphClkEn,
    input wire logic internal_reset,
    input wire logic resetPinOe,
    input wire logic resetPinOut,
    input wire logic inStop,
    input wire logic wakeEvent,
    input wire logic short_stop_recovery,
    input wire logic monitorMode,
    input wire logic regRd,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] irqMidIn,
    input wire logic [7:0] irqHighIn,
    input wire logic [15:0] resetVector
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // Multi-step behaviours as named sequences
    sequence busGap;
        !busClkEn ##1 !busClkEn ##1 !busClkEn ##1 busClkEn;
    endsequence
    sequence stopHold;
        inStop [*8];
    endsequence
    sequence tailHold;
        internal_reset [*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    bus_quarter_a: assert property (busClkEn |=> busGap)
        else $error("bus clock enable not every fourth cycle");
    wait_cpu_off_a: assert property (waitReq [*2] |-> !cpuClkEn)
        else $error("cpu clock running in wait");
    reset_clk_off_a: assert property (internal_reset [*2] |-> !cpuClkEn && !periphClkEn)
        else $error("clocks running under internal reset");
    pin_under_rst_a: assert property (resetPinOe [*2] |-> internal_reset && !resetPinOut)
        else $error("pin driven without internal reset");
    reset_tail_a: assert property (
        $fell(resetPinOe) |-> tailHold ##[24:30] $fell(internal_reset))
        else $error("internal reset tail length wrong");
    stop_clk_off_a: assert property (inStop [*2] |-> !cpuClkEn && !periphClkEn)
        else $error("clocks running in stop");
    stop_short_a: assert property (
        wakeEvent && inStop && short_stop_recovery |-> stopHold ##[20:30] !inStop)
        else $error("short stop recovery length wrong");
    vector_sel_a: assert property (
        $fell(internal_reset) |->
        resetVector == (monitorMode ? VECTOR_MONITOR : VECTOR_NORMAL))
        else $error("reset vector wrong");
    mid_read_a: assert property (
        regRd && regAddr == OFS_IRQ_MID && $stable(irqMidIn) |=>
        regRdata == $past(irqMidIn))
        else $error("mid flag read wrong");
    high_read_a: assert property (
        regRd && regAddr == OFS_IRQ_HIGH && $stable(irqHighIn) |=>
        regRdata == ($past(irqHighIn) & IRQ_HIGH_MASK))
        else $error("high flag read wrong");
endmodule
bind srb_reset_ctrl srb_checker chk (.mclk, .sys_rst, .busClkEn, .waitReq, .cpuClkEn, .periphClkEn,
    .internal_reset, .resetPinOe, .resetPinOut, .inStop, .wakeEvent, .short_stop_recovery,
    .monitorMode, .regRd, .regAddr, .regRdata, .irqMidIn, .irqHighIn, .resetVector);
`default_nettype wire

// ### bench/srb_pin_model.sv
// Reset pin line with pull-up, shared by the block and an outside driver
`timescale 1ns/1ps
`default_nettype none
module srb_pin_model (
    input wire logic resetPinOe,
    input wire logic resetPinOut,
    input wire logic extPull,
    output logic resetPinIn
);
    // Any low driver wins, pull-up otherwise
    assign resetPinIn = extPull ? 1'b0 : (resetPinOe ? resetPinOut : 1'b1);
endmodule
`default_nettype wire

// ### bench/tb_system_reset_and_bus_clock_ctrl.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_system_reset_and_bus_clock_ctrl;
    import srb_pkg::*;
    logic mclk = 0, sys_rst = 1, por = 0, lvr = 0, wdog = 0, ilop = 0, ilad = 0, mon = 0;
    logic ssr = 0, stopReq = 0, waitReq = 0, wake = 0, extPull = 0, regWr = 0, regRd = 0;
    logic [15:0] regAddr = 0;
    logic [7:0] regWdata = 0, irqMid = 0, irqHigh = 0, regRdata;
    logic resetPinIn, resetPinOut, resetPinOe, internal_reset, cpuClkEn, periphClkEn, inStop;
    logic clockgenEnable, busClkEn;
    logic [15:0] resetVector;
    logic [CNT_W-1:0] sysCounter, cntBase;
    int err_count = 0, n_compared = 0, seed = 32'h73ec311b, n, pinRun = 0, pinLen = 0;
    int tailRun = 0, tailLen = 0, cyc = 0;
    always #5 mclk = ~mclk;
    srb_reset_ctrl #(.SETTLE_CYCLES(64), .STOP_LONG(64)) dut (.mclk, .sys_rst,
        .poweron_reset_pulse(por), .low_voltage_reset(lvr), .watchdog_timeout(wdog),
        .illegalOpcode(ilop), .illegalAddress(ilad), .monitorMode(mon),
        .short_stop_recovery(ssr), .stopReq, .waitReq, .wakeEvent(wake), .resetPinIn,
        .resetPinOut, .resetPinOe, .internal_reset, .clockgenEnable, .cpuClkEn, .periphClkEn,
        .busClkEn, .resetVector, .sysCounter, .inStop, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .irqMidIn(irqMid), .irqHighIn(irqHigh));
    srb_pin_model pin (.resetPinOe, .resetPinOut, .extPull, .resetPinIn);
    ////////////////////////////////////////////////////////////////////////////
    // Run lengths of pin drive and of the reset tail after it
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        pinRun <= resetPinOe ? pinRun + 1 : 0;
        if (!resetPinOe && pinRun != 0) pinLen <= pinRun;
        tailRun <= (internal_reset && !resetPinOe) ? tailRun + 1 : 0;
        if (!internal_reset && tailRun != 0) tailLen <= tailRun;
    end
    function automatic int pinExp(input int i);
        return (i < 2) ? 64 + PIN_DRIVE_CYC : PIN_DRIVE_CYC;
    endfunction
    function automatic logic [15:0] vecExp(input logic m);
        return m ? VECTOR_MONITOR : VECTOR_NORMAL;
    endfunction
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
        @(posedge mclk);
        regRd <= 1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 0;
        // Data stands in the cycle after the strobe; taken at its closing edge
        @(posedge mclk);
        `CHK(nm, e, regRdata)
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 0;
    endtask
    // Bounded wait for internal reset release; a hang past 6000 cycles counts as an error
    task automatic waitRel();
        n = 0;
        do @(posedge mclk); while (internal_reset !== 1'b0 && n++ < 6000);
        if (internal_reset !== 1'b0) err_count++;
        @(posedge mclk);
    endtask
    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #300000;
        err_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 0;
        waitRel();
        rd(OFS_RESET_CAUSE, 8'h80, "cause_por");
        rd(OFS_RESET_CAUSE, 8'h00, "cause_clr");
        // Random flags, read-only places and an unmapped address
        repeat (6) begin
            irqMid <= 8'($random(seed));
            irqHigh <= 8'($random(seed));
            wr(OFS_IRQ_MID, 8'h5a);
            rd(OFS_IRQ_MID, irqMid, "irq_mid");
            rd(OFS_IRQ_HIGH, irqHigh & IRQ_HIGH_MASK, "irq_high");
            rd(16'hfe07, 8'h00, "unmapped");
        end
        // Every internal source: pin drive length, tail, vector and cause flag
        for (int i = 0; i < 5; i++) begin
            mon <= i[0];
            @(posedge mclk);
            case (i)
                0: por <= 1;
                1: lvr <= 1;
                2: wdog <= 1;
                3: ilop <= 1;
                default: ilad <= 1;
            endcase
            repeat ((i == 1 || i == 2) ? 2 : 1) @(posedge mclk);
            {por, lvr, wdog, ilop, ilad} <= 5'h00;
            repeat (4) @(posedge mclk);
            if (i == 0) `CHK("cgen", 1'b1, clockgenEnable)
            waitRel();
            `CHK("pin_len", pinExp(i), pinLen)
            `CHK("tail_len", PIN_DRIVE_CYC + RECOVERY_EXTRA_CYC, tailLen)
            `CHK("vector", vecExp(mon), resetVector)
            rd(OFS_RESET_CAUSE, 8'h01 << ((i == 0) ? CAUSE_POR : (i == 1) ? CAUSE_LVR :
                (i == 2) ? CAUSE_WDOG : (i == 3) ? CAUSE_ILOP : CAUSE_ILAD), "cause_src");
        end
        // Pin reset, long enough and too short
        for (int k = 2; k <= 8; k += 6) begin
            // Counter must run straight through a pin-only reset
            cntBase = sysCounter - CNT_W'(cyc);
            extPull <= 1;
            repeat (k) @(posedge mclk);
            extPull <= 0;
            repeat (4) @(posedge mclk);
            waitRel();
            rd(OFS_RESET_CAUSE, (k >= PIN_MIN_LOW_CYC) ? 8'h40 : 8'h00, "cause_pin");
            `CHK("cnt_keep", cntBase, sysCounter - CNT_W'(cyc))
        end
        // Stop entry and both recovery delays
        for (int s = 0; s < 2; s++) begin
            ssr <= s[0];
            stopReq <= 1;
            @(posedge mclk);
            stopReq <= 0;
            repeat (4) @(posedge mclk);
            `CHK("stop_clk", 2'b00, {cpuClkEn, periphClkEn})
            @(posedge mclk);
            wake <= 1;
            @(posedge mclk);
            wake <= 0;
            n = 0;
            do @(posedge mclk); while (cpuClkEn !== 1'b1 && n++ < 200);
            `CHK("stop_len", 1'b1, n >= (s ? STOP_SHORT_CYC : 64) - 2 && n <= (s ? 36 : 68))
        end
        // Wait mode keeps peripherals clocked
        waitReq <= 1;
        repeat (3) @(posedge mclk);
        `CHK("wait_clk", 2'b01, {cpuClkEn, periphClkEn})
        waitReq <= 0;
        complete_run();
    end
endmodule
`default_nettype wire

// ### hdl/srb_pkg.sv
// Constants for the reset sequencer and bus clock controller
// Functional notes
// - Bus clock enable is clock generator output halved, quarter of oscillator.
// - After power-on or low voltage, bus clocks wait 4096 cycles, pin low.
// - Stop exit waits 4096 or 32 oscillator cycles before clocks restart.
// - Wait mode stops CPU clock but peripheral clock keeps running.
// - Any reset asserts internal reset and selects normal or monitor vector.
// - Internal reset returns every register and module to default state. Here it reloads only the irqMid and irqHigh flag registers.
// - Internal resets clear system counter; pin-only reset leaves it alone.
// - Each reset source sets its matching cause flag.
// - Low reset pin halts all processing; pull-up keeps it high otherwise.
// - Pin flag set only after minimum low time with no other source.
// - Recovery takes 4163 cycles for power-on or low voltage, else 67.
// - Internal sources drive pin low 32 cycles, then reset 32 more. Here reset stays asserted 35 more (32 hold plus 3 tail).
// - Power-on and low voltage drive pin low 4096 plus 32 cycles.
// - Watchdog timeout is accepted asynchronously to the bus clock.
// - CPU released 32 cycles after power-on reset releases the pin. Here it is released 35 cycles after (32 hold plus 3 tail).
// - Clock generator output enabled while power-on internal reset asserted.
// - Power-on sets its cause flag and clears all other flags.
// - System counter is 12 bits wide.
// - Short stop recovery option selects 32 cycles instead of 4096.
package srb_pkg;
    localparam int CNT_W = 12;
    localparam logic [15:0] OFS_IRQ_MID = 16'hfe05;
    localparam logic [15:0] OFS_IRQ_HIGH = 16'hfe06;
    localparam logic [15:0] OFS_RESET_CAUSE = 16'hfe01;
    localparam logic [7:0] IRQ_MID_RESET = 8'h00;
    localparam logic [7:0] IRQ_HIGH_RESET = 8'h00;
    localparam logic [7:0] IRQ_HIGH_MASK = 8'h7f;
    localparam logic [15:0] VECTOR_NORMAL = 16'hfffe;
    localparam logic [15:0] VECTOR_MONITOR = 16'hfefe;
    // Cause flag positions
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_PIN = 6;
    localparam int CAUSE_WDOG = 5;
    localparam int CAUSE_ILOP = 4;
    localparam int CAUSE_ILAD = 3;
    localparam int CAUSE_LVR = 1;
    // Cycle counts
    localparam int OSC_SETTLE_CYC = 4096;
    localparam int PIN_DRIVE_CYC = 32;
    localparam int INTERNAL_RESET_HOLD_CYC = 32;
    localparam int STOP_LONG_CYC = 4096;
    localparam int STOP_SHORT_CYC = 32;
    localparam int RECOVERY_EXTRA_CYC = 3;
    localparam int PIN_MIN_LOW_CYC = 4;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETTLE = 3'b001,
        ST_DRIVE = 3'b011,
        ST_HOLD = 3'b010,
        ST_TAIL = 3'b110,
        ST_PINLOW = 3'b111,
        ST_STOPREC = 3'b101
    } srb_state_type;
endpackage

// ### hdl/srb_reset_ctrl.sv
// Reset sequencer, cause register and bus clock gating
`timescale 1ns/1ps
`default_nettype none
module srb_reset_ctrl
    import srb_pkg::*;
#(
    parameter int SETTLE_CYCLES = OSC_SETTLE_CYC,
    parameter int STOP_LONG = STOP_LONG_CYC,
    parameter int STOP_SHORT = STOP_SHORT_CYC,
    parameter int PIN_MIN_LOW = PIN_MIN_LOW_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic poweron_reset_pulse,
    input wire logic low_voltage_reset,
    input wire logic watchdog_timeout,
    input wire logic illegalOpcode,
    input wire logic illegalAddress,
    input wire logic monitorMode,
    input wire logic short_stop_recovery,
    input wire logic stopReq,
    input wire logic waitReq,
    input wire logic wakeEvent,
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe,
    output logic internal_reset,
    output logic clockgenEnable,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic busClkEn,
    output logic [15:0] resetVector,
    output logic [CNT_W-1:0] sysCounter,
    output logic inStop,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [7:0] irqMidIn,
    input wire logic [7:0] irqHighIn
);
    localparam int RECOVER_WAIT = PIN_DRIVE_CYC + RECOVERY_EXTRA_CYC;
    localparam int PIN_WAIT = SETTLE_CYCLES + PIN_DRIVE_CYC;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation
    logic pinSync;
    logic wdogSync;
    logic lvrSync;
    logic pinLowN;
    srb_sync #(.INIT(1'b1)) u_pin_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(resetPinIn),
        .dout(pinSync)
    );
    // Watchdog comes from another clock relation, sampled here
    srb_sync #(.INIT(1'b0)) u_wdog_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(watchdog_timeout),
        .dout(wdogSync)
    );
    srb_sync #(.INIT(1'b0)) u_lvr_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(low_voltage_reset),
        .dout(lvrSync)
    );
    assign pinLowN = pinSync;

    ////////////////////////////////////////////////////////////////////////
    // State machine and counters
    srb_state_type state;
    srb_state_type next_state;
    logic [12:0] phaseCnt;
    logic [5:0] pinLowCnt;
    logic internalSrc;
    logic [7:0] causePend;
    logic stopShort;
    logic seqStart;
    logic pinHeld;

    assign internalSrc = poweron_reset_pulse | lvrSync | wdogSync | illegalOpcode | illegalAddress;
    assign pinHeld = (pinLowCnt >= 6'(PIN_MIN_LOW));
    assign seqStart = internalSrc && state != ST_SETTLE && state != ST_DRIVE;

    // Next state; a fresh internal source restarts the sequence unless already in settle or drive
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (!pinLowN) next_state = ST_PINLOW;
                else if (stopReq) next_state = ST_STOPREC;
            end
            ST_SETTLE: begin
                if (phaseCnt == 13'(PIN_WAIT - 1)) next_state = ST_HOLD;
            end
            ST_DRIVE: begin
                if (phaseCnt == 13'(PIN_DRIVE_CYC - 1)) next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (phaseCnt == 13'(INTERNAL_RESET_HOLD_CYC - 1)) next_state = ST_TAIL;
            end
            ST_TAIL: begin
                if (phaseCnt == 13'(RECOVERY_EXTRA_CYC - 1)) next_state = ST_IDLE;
            end
            ST_PINLOW: begin
                if (pinLowN) next_state = ST_HOLD;
            end
            ST_STOPREC: begin
                // Wake is a pulse; phase 1 remembers it while the delay runs out
                if (phaseCnt != 13'h0000 &&
                    sysCounter >= (stopShort ? 12'(STOP_SHORT - 1) : 12'(STOP_LONG - 1)))
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        if (seqStart) begin
            next_state = (poweron_reset_pulse | lvrSync) ? ST_SETTLE : ST_DRIVE;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) state <= ST_SETTLE;
        else state <= next_state;
    end

    // Phase counter restarts on every state change
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) phaseCnt <= 13'h0000;
        else if (next_state != state || seqStart) phaseCnt <= 13'h0000;
        else if (state == ST_STOPREC) phaseCnt <= wakeEvent ? 13'h0001 : phaseCnt;
        else phaseCnt <= phaseCnt + 13'h0001;
    end

    // Stop option sampled at stop exit request
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) stopShort <= 1'b0;
        else if (state == ST_STOPREC && wakeEvent) stopShort <= short_stop_recovery;
    end

    // System counter: cleared by internal resets, stop entry and in stop until wake, free running otherwise
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) sysCounter <= '0;
        else if (seqStart) sysCounter <= '0;
        else if (state == ST_IDLE && stopReq && pinLowN) sysCounter <= '0;
        else if (state == ST_STOPREC && !wakeEvent && phaseCnt == 13'h0000) sysCounter <= '0;
        else sysCounter <= sysCounter + 12'h001;
    end

    // Pin low time measured for the pin cause flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) pinLowCnt <= '0;
        else if (pinLowN) pinLowCnt <= '0;
        else if (!pinHeld) pinLowCnt <= pinLowCnt + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset cause register; power-on wipes all other flags
    logic [7:0] resetCause;
    always_comb begin
        causePend = 8'h00;
        causePend[CAUSE_WDOG] = wdogSync;
        causePend[CAUSE_ILOP] = illegalOpcode;
        causePend[CAUSE_ILAD] = illegalAddress;
        causePend[CAUSE_LVR] = lvrSync;
        // Our own pull-down must not count as an outside pin reset
        causePend[CAUSE_PIN] = pinHeld && state == ST_PINLOW && !internalSrc;
    end
    logic causeReadClear;
    assign causeReadClear = regRd && regAddr == OFS_RESET_CAUSE;
    // Read clears; a new event in the same cycle still sets
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) resetCause <= 8'h80;
        else if (poweron_reset_pulse) resetCause <= 8'h80;
        else resetCause <= (causeReadClear ? 8'h00 : resetCause) | causePend;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: pin drive, internal reset, clock enables
    logic resetActive;
    assign resetActive = state == ST_SETTLE || state == ST_DRIVE || state == ST_HOLD ||
                         state == ST_TAIL || state == ST_PINLOW;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            resetPinOe <= 1'b1;
            internal_reset <= 1'b1;
        end else begin
            resetPinOe <= next_state == ST_SETTLE || next_state == ST_DRIVE;
            internal_reset <= next_state != ST_IDLE && next_state != ST_STOPREC;
        end
    end
    assign resetPinOut = 1'b0; // Open drain: only ever pulls low

    // Clock generator output enabled from power-on onward
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) clockgenEnable <= 1'b1;
        else if (poweron_reset_pulse) clockgenEnable <= 1'b1;
    end

    // Bus clock enable: clock generator halves its input, we halve again
    logic [1:0] divCnt;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) divCnt <= 2'b00;
        else if (clockgenEnable) divCnt <= divCnt + 2'b01;
    end
    assign busClkEn = clockgenEnable && divCnt == 2'b11;

    // Gated clock enables; held off during settle and stop recovery
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cpuClkEn <= 1'b0;
            periphClkEn <= 1'b0;
        end else begin
            periphClkEn <= next_state == ST_IDLE;
            cpuClkEn <= next_state == ST_IDLE && !waitReq;
        end
    end
    assign inStop = state == ST_STOPREC;

    // Vector pair chosen by monitor mode
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) resetVector <= VECTOR_NORMAL;
        else if (resetActive) resetVector <= monitorMode ? VECTOR_MONITOR : VECTOR_NORMAL;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port, data one cycle after strobe
    logic [7:0] irqMid;
    logic [7:0] irqHigh;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irqMid <= IRQ_MID_RESET;
            irqHigh <= IRQ_HIGH_RESET;
        end else if (internal_reset) begin
            irqMid <= IRQ_MID_RESET;
            irqHigh <= IRQ_HIGH_RESET;
        end else begin
            irqMid <= irqMidIn;
            irqHigh <= irqHighIn & IRQ_HIGH_MASK;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) regRdata <= 8'h00;
        else if (regRd) begin
            case (regAddr)
                OFS_IRQ_MID: regRdata <= irqMid;
                OFS_IRQ_HIGH: regRdata <= irqHigh;
                OFS_RESET_CAUSE: regRdata <= resetCause;
                default: regRdata <= 8'h00;
            endcase
        end
    end
    // Writes are accepted and ignored; all registers here are read only
    logic unusedWrite;
    assign unusedWrite = regWr & ^regWdata;
endmodule
`default_nettype wire

// ### hdl/srb_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module srb_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    logic stage1;
    // Only the second flop reads the first
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= INIT;
            dout <= INIT;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire
